// ### core/mtx_top.sv
// Modem transmit character engine with status flags and Wishbone slave
//
// The implementer's own choices: the register addresses and the Wishbone register port.
module mtx_top #(
  parameter int unsigned BIT_DIV_300  = mtx_pkg::CLK_HZ / mtx_pkg::RATE_300,
  parameter int unsigned BIT_DIV_1200 = mtx_pkg::CLK_HZ / mtx_pkg::RATE_1200,
  parameter int unsigned BIT_DIV_75   = mtx_pkg::CLK_HZ / mtx_pkg::RATE_75,
  parameter int unsigned BIT_DIV_150  = mtx_pkg::CLK_HZ / mtx_pkg::RATE_150
) (
  input  wire logic        CLK_SYS,
  input  wire logic        RST_N,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [11:0] WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  input  wire logic        RING_IN,
  input  wire logic        DET_DTMF,
  input  wire logic        DET_TONE1,
  input  wire logic        DET_TONE2,
  input  wire logic        DET_CPROG,
  input  wire logic        DET_ANS_2225,
  input  wire logic        DET_ANS_2100,
  output logic             TX_SER,
  output logic             TX_FSK_EN,
  output logic      [3:0]  TX_FSK_MODE,
  output logic             TX_EQ_EN,
  output logic             TX_TONE_EN,
  output logic      [3:0]  TX_TONE_SEL,
  output logic      [3:0]  RX_MODE,
  output logic             POWER_SAVE
);

  mtx_pkg::mtx_state_t s_r;
  mtx_pkg::mtx_state_t s_nxt;
  logic                xfer_c;
  logic                load_c;

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------

  // Bit period in clocks for an FSK transmit mode
  function automatic logic [20:0] div_sel(input logic [3:0] m);
    case (m)
      mtx_pkg::TXMD_B103:      div_sel = 21'(BIT_DIV_300);
      mtx_pkg::TXMD_V23_75:    div_sel = 21'(BIT_DIV_75);
      mtx_pkg::TXMD_B202_150:  div_sel = 21'(BIT_DIV_150);
      default:                 div_sel = 21'(BIT_DIV_1200);
    endcase
  endfunction

  // Mode uses the FSK modulator
  function automatic logic is_fsk(input logic [3:0] m);
    is_fsk = (m >= mtx_pkg::TXMD_B103) && (m <= mtx_pkg::TXMD_B202_150);
  endfunction

  // Mode runs at 1200 bit/s
  function automatic logic is_1200(input logic [3:0] m);
    is_1200 = (m == mtx_pkg::TXMD_V23_1200) ||
              (m == mtx_pkg::TXMD_B202_1200);
  endfunction

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------

  // Bus slave, bit timer, character engine and status
  always_comb begin
    logic        go;
    logic        wr;
    logic        psave;
    logic        active;
    logic [3:0]  txmode;
    logic [1:0]  fmt;
    logic [2:0]  last;
    logic [2:0]  nbit;
    logic [7:0]  nb;
    logic [7:0]  mask;
    logic [20:0] per;
    s_nxt  = s_r;
    xfer_c = 1'b0;
    load_c = 1'b0;
    go     = WB_CYC_I & WB_STB_I & ~s_r.ack;
    wr     = go & WB_WE_I;
    psave  = s_r.gc[mtx_pkg::GC_PSAVE];
    txmode = s_r.txm[mtx_pkg::MODE_LSB +: 4];
    fmt    = s_r.txm[mtx_pkg::TXM_FMT +: 2];
    last   = 3'd4 + {1'b0, s_r.txm[mtx_pkg::TXM_DBL +: 2]};
    nbit   = s_r.bitn + 3'd1;
    nb     = s_r.pend ? s_r.dreg : s_r.sbuf;
    mask   = 8'hff >> (2'd3 - s_r.txm[mtx_pkg::TXM_DBL +: 2]);
    per    = div_sel(txmode);
    active = is_fsk(txmode) & ~psave;

    // Single-cycle acknowledge; unmapped reads return zero
    s_nxt.ack  = go;
    s_nxt.rdat = 32'h0;
    if (go && !WB_WE_I && WB_ADR_I[11:2] == mtx_pkg::IDX_STATUS) begin
      s_nxt.rdat = {16'h0, s_r.stat};
    end

    // Register writes honour byte lanes; the reset command clears regardless of them
    if (wr) begin
      case (WB_ADR_I[11:2])
        mtx_pkg::IDX_GCTRL: begin
          if (WB_SEL_I[0]) s_nxt.gc[7:0] = WB_DAT_I[7:0];
          if (WB_SEL_I[1]) s_nxt.gc[15:8] = WB_DAT_I[15:8];
        end
        mtx_pkg::IDX_TXMODE: begin
          if (WB_SEL_I[0]) s_nxt.txm[7:0] = WB_DAT_I[7:0];
          if (WB_SEL_I[1]) s_nxt.txm[15:8] = WB_DAT_I[15:8];
        end
        mtx_pkg::IDX_RXMODE: begin
          if (WB_SEL_I[0]) s_nxt.rxm[7:0] = WB_DAT_I[7:0];
          if (WB_SEL_I[1]) s_nxt.rxm[15:8] = WB_DAT_I[15:8];
        end
        mtx_pkg::IDX_TXDATA: begin
          if (WB_SEL_I[0]) begin
            s_nxt.dreg  = WB_DAT_I[7:0];
            s_nxt.pend  = 1'b1;
            s_nxt.ready = 1'b0;
            s_nxt.undf  = 1'b0;
          end
        end
        mtx_pkg::IDX_RESET: begin
          s_nxt.gc  = 16'h0;
          s_nxt.txm = 16'h0;
          s_nxt.rxm = 16'h0;
        end
        default: begin
        end
      endcase
    end

    // Bit period timer, idle at mark while not in an FSK mode or in powersave
    if (!active) begin
      s_nxt.div   = 21'h0;
      s_nxt.st    = mtx_pkg::TS_IDLE;
      s_nxt.ser   = 1'b1;
      s_nxt.bitn  = 3'h0;
      s_nxt.stop2 = 1'b0;
    end else if (s_r.div >= per - 21'h1) begin
      s_nxt.div = 21'h0;
      case (fmt)
        mtx_pkg::FMT_ALT: begin
          s_nxt.st  = mtx_pkg::TS_IDLE;
          s_nxt.ser = ~s_r.ser;
        end
        mtx_pkg::FMT_MARK: begin
          s_nxt.st  = mtx_pkg::TS_IDLE;
          s_nxt.ser = 1'b1;
        end
        mtx_pkg::FMT_SYNC: begin
          if (s_r.st != mtx_pkg::TS_DATA || s_r.bitn == 3'd7) begin
            xfer_c     = 1'b1;
            s_nxt.st   = mtx_pkg::TS_DATA;
            s_nxt.bitn = 3'h0;
            s_nxt.ser  = nb[0];
          end else begin
            s_nxt.bitn = nbit;
            s_nxt.ser  = s_r.sbuf[nbit];
          end
        end
        default: begin
          case (s_r.st)
            mtx_pkg::TS_START: begin
              s_nxt.st   = mtx_pkg::TS_DATA;
              s_nxt.bitn = 3'h0;
              s_nxt.ser  = s_r.sbuf[0];
            end
            mtx_pkg::TS_DATA: begin
              if (s_r.bitn == last) begin
                s_nxt.stop2 = 1'b0;
                if (s_r.txm[mtx_pkg::TXM_PEN]) begin
                  s_nxt.st  = mtx_pkg::TS_PAR;
                  s_nxt.ser = (^(s_r.sbuf & mask)) ^
                              ~s_r.txm[mtx_pkg::TXM_PEVN];
                end else begin
                  s_nxt.st  = mtx_pkg::TS_STOP;
                  s_nxt.ser = 1'b1;
                end
              end else begin
                s_nxt.bitn = nbit;
                s_nxt.ser  = s_r.sbuf[nbit];
              end
            end
            mtx_pkg::TS_PAR: begin
              s_nxt.st    = mtx_pkg::TS_STOP;
              s_nxt.ser   = 1'b1;
              s_nxt.stop2 = 1'b0;
            end
            default: begin
              if (s_r.st == mtx_pkg::TS_STOP &&
                  s_r.txm[mtx_pkg::TXM_STP2] && !s_r.stop2) begin
                s_nxt.stop2 = 1'b1;
                s_nxt.ser   = 1'b1;
              end else begin
                xfer_c = 1'b1;
                if (s_r.pend) begin
                  s_nxt.st  = mtx_pkg::TS_START;
                  s_nxt.ser = 1'b0;
                end else begin
                  s_nxt.st  = mtx_pkg::TS_IDLE;
                  s_nxt.ser = 1'b1;
                end
              end
            end
          endcase
        end
      endcase
    end else begin
      s_nxt.div = s_r.div + 21'h1;
    end

    // Register-to-buffer transfer; a same-cycle data write keeps pend set and ready clear
    if (xfer_c) begin
      if (s_r.pend) begin
        load_c      = 1'b1;
        s_nxt.sbuf  = s_r.dreg;
        s_nxt.seen  = 1'b1;
        s_nxt.ready = 1'b1;
        if (!(wr && WB_ADR_I[11:2] == mtx_pkg::IDX_TXDATA && WB_SEL_I[0]))
        begin
          s_nxt.pend = 1'b0;
        end else begin
          s_nxt.ready = 1'b0;
        end
      end else if (s_r.seen) begin
        s_nxt.undf = 1'b1;
      end
    end

    // Path enables for modulator, equaliser and tone generator
    s_nxt.fsk_en  = active;
    s_nxt.eq_en   = active & is_1200(txmode) &
                    s_r.gc[mtx_pkg::GC_EQ];
    s_nxt.tone_en = ~psave & (txmode >= mtx_pkg::TXMD_DTMF) &
                    (txmode <= mtx_pkg::TXMD_USER);
    s_nxt.rx_mode = psave ? 4'h0 : s_r.rxm[mtx_pkg::MODE_LSB +: 4];

    // Status word: only the selected receive mode's detectors report, ring survives powersave
    s_nxt.stat = 16'h0;
    s_nxt.stat[mtx_pkg::ST_RDY]  = s_nxt.ready;
    s_nxt.stat[mtx_pkg::ST_UNDF] = s_nxt.undf;
    s_nxt.stat[mtx_pkg::ST_RING] = RING_IN;
    case (s_nxt.rx_mode)
      mtx_pkg::RXMD_DTMF: begin
        s_nxt.stat[mtx_pkg::ST_DTMF] = DET_DTMF;
      end
      mtx_pkg::RXMD_PAIR: begin
        s_nxt.stat[mtx_pkg::ST_T1]   = DET_TONE1;
        s_nxt.stat[mtx_pkg::ST_T2]   = DET_TONE2;
        s_nxt.stat[mtx_pkg::ST_BOTH] = DET_TONE1 & DET_TONE2;
      end
      mtx_pkg::RXMD_CPROG: begin
        s_nxt.stat[mtx_pkg::ST_BOTH] = DET_CPROG;
      end
      mtx_pkg::RXMD_ANS: begin
        s_nxt.stat[mtx_pkg::ST_T1] = DET_ANS_2225;
        s_nxt.stat[mtx_pkg::ST_T2] = DET_ANS_2100;
      end
      default: begin
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // State register and outputs
  // ----------------------------------------------------------------------

  // Synchronous active-low reset
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      s_r <= mtx_pkg::ST_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Ports come straight from the state register
  assign WB_DAT_O    = s_r.rdat;
  assign WB_ACK_O    = s_r.ack;
  assign TX_SER      = s_r.ser;
  assign TX_FSK_EN   = s_r.fsk_en;
  assign TX_FSK_MODE = s_r.txm[mtx_pkg::MODE_LSB +: 4];
  assign TX_EQ_EN    = s_r.eq_en;
  assign TX_TONE_EN  = s_r.tone_en;
  assign TX_TONE_SEL = s_r.txm[mtx_pkg::TXM_TONE +: 4];
  assign RX_MODE     = s_r.rx_mode;
  assign POWER_SAVE  = s_r.gc[mtx_pkg::GC_PSAVE];

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------

  a_ready_on_load: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    load_c |=> s_r.ready == !s_r.pend &&
               s_r.stat[mtx_pkg::ST_RDY] == s_r.ready)
    else $error("ready not set after buffer load");

  a_ready_clear_wr: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    (WB_CYC_I && WB_STB_I && WB_WE_I && !s_r.ack && WB_SEL_I[0] &&
     WB_ADR_I[11:2] == mtx_pkg::IDX_TXDATA && !xfer_c) |=> !s_r.ready)
    else $error("ready not cleared by data write");

  a_underflow_set: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    (xfer_c && !s_r.pend && s_r.seen) |=>
      s_r.undf && s_r.stat[mtx_pkg::ST_UNDF])
    else $error("underflow not flagged");

  a_sync_lsb_first: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    (xfer_c && s_r.txm[5:4] == mtx_pkg::FMT_SYNC) |=> s_r.ser == s_r.sbuf[0])
    else $error("sync word not sent lsb first");

  a_start_bit_low: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    (s_r.st == mtx_pkg::TS_START) |-> !s_r.ser)
    else $error("start bit not low");

  a_async_mark_idle: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    (s_r.txm[5:4] == mtx_pkg::FMT_ASYNC &&
     (s_r.st == mtx_pkg::TS_IDLE || s_r.st == mtx_pkg::TS_STOP)) |-> s_r.ser)
    else $error("line not at stop level");

  a_eq_gate: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    $rose(TX_EQ_EN) |-> $past(s_r.gc[mtx_pkg::GC_EQ]) && TX_FSK_EN)
    else $error("equaliser enabled without control bit");

  a_psave_quiet: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    s_r.gc[mtx_pkg::GC_PSAVE] |=> !TX_FSK_EN && !TX_TONE_EN &&
                                  RX_MODE == 4'h0 && s_r.stat[10:5] == 6'h0)
    else $error("powersave left a function running");

  a_dtmf_status: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    (s_nxt.rx_mode == mtx_pkg::RXMD_DTMF) |=>
      s_r.stat[mtx_pkg::ST_DTMF] == $past(DET_DTMF))
    else $error("dtmf status bit wrong");

endmodule

// ### core/mtx_pkg.sv
// Constants, types and reset state of the modem transmit character engine
package mtx_pkg;

  // ----------------------------------------------------------------------
  // Register word indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [9:0] IDX_RESET  = 10'h001;
  localparam logic [9:0] IDX_GCTRL  = 10'h0e0;
  localparam logic [9:0] IDX_TXMODE = 10'h0e1;
  localparam logic [9:0] IDX_RXMODE = 10'h0e2;
  localparam logic [9:0] IDX_TXDATA = 10'h0e3;
  localparam logic [9:0] IDX_STATUS = 10'h0e6;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int GC_PSAVE = 8;   // Powersave
  localparam int GC_EQ    = 10;  // Transmit equaliser enable
  localparam int TXM_PEVN = 0;   // Even parity when set
  localparam int TXM_PEN  = 1;   // Parity bit present
  localparam int TXM_DBL  = 2;   // Data bits minus five, two bits
  localparam int TXM_FMT  = 4;   // Character format, two bits
  localparam int TXM_STP2 = 6;   // Two stop bits
  localparam int TXM_TONE = 8;   // Tone select, four bits
  localparam int MODE_LSB = 12;  // Mode field, four bits
  localparam int ST_DTMF  = 5;
  localparam int ST_T1    = 6;
  localparam int ST_T2    = 7;
  localparam int ST_BOTH  = 10;
  localparam int ST_UNDF  = 11;
  localparam int ST_RDY   = 12;
  localparam int ST_RING  = 14;

  // ----------------------------------------------------------------------
  // Mode and format codes
  // ----------------------------------------------------------------------
  localparam logic [3:0] TXMD_B103      = 4'h1;
  localparam logic [3:0] TXMD_V23_1200  = 4'h2;
  localparam logic [3:0] TXMD_V23_75    = 4'h3;
  localparam logic [3:0] TXMD_B202_1200 = 4'h4;
  localparam logic [3:0] TXMD_B202_150  = 4'h5;
  localparam logic [3:0] TXMD_DTMF      = 4'h6;
  localparam logic [3:0] TXMD_TONE      = 4'h7;
  localparam logic [3:0] TXMD_USER      = 4'h8;
  localparam logic [3:0] RXMD_DTMF      = 4'h4;
  localparam logic [3:0] RXMD_ANS       = 4'h5;
  localparam logic [3:0] RXMD_CPROG     = 4'h6;
  localparam logic [3:0] RXMD_PAIR      = 4'h7;
  localparam logic [1:0] FMT_SYNC       = 2'h0;
  localparam logic [1:0] FMT_ASYNC      = 2'h1;
  localparam logic [1:0] FMT_ALT        = 2'h2;
  localparam logic [1:0] FMT_MARK       = 2'h3;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ    = 125_000_000;
  localparam int unsigned RATE_300  = 300;
  localparam int unsigned RATE_1200 = 1200;
  localparam int unsigned RATE_75   = 75;
  localparam int unsigned RATE_150  = 150;

  typedef enum logic [4:0] {
    TS_IDLE  = 5'b00001,
    TS_START = 5'b00010,
    TS_DATA  = 5'b00100,
    TS_PAR   = 5'b01000,
    TS_STOP  = 5'b10000
  } mtx_tx_state_t;

  typedef struct packed {
    logic [15:0]   gc;
    logic [15:0]   txm;
    logic [15:0]   rxm;
    logic [15:0]   stat;
    logic [7:0]    dreg;
    logic [7:0]    sbuf;
    logic          pend;
    logic          seen;
    logic          ready;
    logic          undf;
    logic          ser;
    logic          stop2;
    logic          fsk_en;
    logic          eq_en;
    logic          tone_en;
    logic          ack;
    logic [3:0]    rx_mode;
    mtx_tx_state_t st;
    logic [2:0]    bitn;
    logic [20:0]   div;
    logic [31:0]   rdat;
  } mtx_state_t;

  localparam logic [15:0] STAT_RESET = 16'h1000;
  localparam mtx_state_t ST_RESET = '{st: TS_IDLE, ser: 1'b1, ready: 1'b1,
                                      stat: STAT_RESET, default: '0};
endpackage

// ### bench/mtx_line_model.sv
// Line-side partner: detector levels, ring level and serial stream decoder
module mtx_line_model (
  input  wire logic       clk,
  input  wire logic       ser,
  output logic      [5:0] det,
  output logic            ring
);
  timeunit 1ns;
  timeprecision 1ps;

  // Quiet line at time zero
  initial begin
    det  = 6'h00;
    ring = 1'b0;
  end

  // Detector and ring levels change just after a clock edge
  task automatic drive(input logic [5:0] d, input logic r);
    @(posedge clk);
    det  <= d;
    ring <= r;
  endtask

  // Waits for a falling edge, then samples each bit in its middle
  task automatic rx_frame(input int n, input int div,
                          output logic [15:0] v, output logic ok);
    int k;
    v  = '0;
    ok = 1'b0;
    for (k = 0; k < 4000 && ser !== 1'b0; k++) @(posedge clk);
    if (ser === 1'b0) begin
      ok = 1'b1;
      repeat (div / 2) @(posedge clk);
      // Return in the middle of the last bit so a following call still
      // sees the next start bit fall
      for (k = 0; k < n; k++) begin
        v[k] = ser;
        if (k < n - 1) repeat (div) @(posedge clk);
      end
    end
  endtask
endmodule

// ### bench/test_modem_tx_usart_tone_flags.sv
// Self-checking bench for the modem transmit character engine
module test_modem_tx_usart_tone_flags;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Signals and constants
  // ----------------------------------------------------------------
  localparam int D300  = 40;
  localparam int D1200 = 10;
  localparam logic [11:0] A_GC = {mtx_pkg::IDX_GCTRL, 2'b00};
  localparam logic [11:0] A_TM = {mtx_pkg::IDX_TXMODE, 2'b00};
  localparam logic [11:0] A_RM = {mtx_pkg::IDX_RXMODE, 2'b00};
  localparam logic [11:0] A_TD = {mtx_pkg::IDX_TXDATA, 2'b00};
  localparam logic [11:0] A_ST = {mtx_pkg::IDX_STATUS, 2'b00};
  logic        clk_sys = 1'b0;
  logic        rst_n   = 1'b0;
  logic        cyc     = 1'b0;
  logic        stb     = 1'b0;
  logic        we      = 1'b0;
  logic [11:0] adr     = 12'h000;
  logic [3:0]  sel     = 4'h0;
  logic [31:0] wdat    = 32'h0;
  logic [31:0] rdat;
  logic        ack, ser, fsk_en, eq_en, tone_en, psave, ring;
  logic [3:0]  fsk_mode, tone_sel, rx_mode;
  logic [5:0]  det;
  int          miscompares = 0;
  int          tests_run   = 0;

  // Free-running system clock
  always #4 clk_sys = ~clk_sys;

  mtx_top #(.BIT_DIV_300(D300), .BIT_DIV_1200(D1200),
            .BIT_DIV_75(160), .BIT_DIV_150(80)) mtx_top_inst (
    .CLK_SYS(clk_sys), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
    .WB_DAT_O(rdat), .WB_ACK_O(ack), .RING_IN(ring),
    .DET_DTMF(det[0]), .DET_TONE1(det[1]), .DET_TONE2(det[2]),
    .DET_CPROG(det[3]), .DET_ANS_2225(det[4]), .DET_ANS_2100(det[5]),
    .TX_SER(ser), .TX_FSK_EN(fsk_en), .TX_FSK_MODE(fsk_mode),
    .TX_EQ_EN(eq_en), .TX_TONE_EN(tone_en), .TX_TONE_SEL(tone_sel),
    .RX_MODE(rx_mode), .POWER_SAVE(psave));

  mtx_line_model mtx_line_model_inst (
    .clk(clk_sys), .ser(ser), .det(det), .ring(ring));

  // ----------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Classic cycle: hold the request until ack is seen at an edge
  task automatic wb(input logic [11:0] a, input logic w,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk_sys);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= 4'h3;
    wdat <= d;
    for (n = 0; n < 20 && ack !== 1'b1; n++) @(posedge clk_sys);
    if (ack !== 1'b1) begin
      miscompares++;
      results();
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    logic [31:0] q;
    wb(a, 1'b1, {16'h0, d}, q);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] m,
                        input logic [31:0] e);
    logic [31:0] q;
    wb(a, 1'b0, 32'h0, q);
    check(q & m, e);
  endtask

  // Polls status until the data register is free again
  task automatic wait_ready();
    logic [31:0] q;
    int n;
    q = '0;
    for (n = 0; n < 400 && q[12] !== 1'b1; n++) wb(A_ST, 1'b0, 32'h0, q);
    check(q[12], 1'b1);
  endtask

  // Expected start-stop frame, start bit in bit 0
  function automatic logic [15:0] fr(input logic [7:0] x, input int nd,
                                     input logic pen, input logic pevn);
    logic [15:0] v;
    logic        p;
    v    = 16'hffff;
    v[0] = 1'b0;
    p    = ~pevn;
    for (int k = 0; k < nd; k++) begin
      v[k + 1] = x[k];
      p ^= x[k];
    end
    if (pen) v[nd + 1] = p;
    return v;
  endfunction

  // Detector status bits expected for a receive mode and inputs
  function automatic logic [15:0] det_exp(input logic [3:0] m,
                                          input logic [5:0] d);
    logic [15:0] s;
    s = 16'h0;
    case (m)
      mtx_pkg::RXMD_DTMF:  s[5] = d[0];
      mtx_pkg::RXMD_ANS:   s[7:6] = {d[5], d[4]};
      mtx_pkg::RXMD_CPROG: s[10] = d[3];
      default:             s[10:6] = {d[1] & d[2], 2'b00, d[2], d[1]};
    endcase
    return s;
  endfunction

  // Two back-to-back characters, then underflow in idle
  task automatic async_run(input logic [3:0] md, input int div,
                           input logic [1:0] dbl, input logic pen,
                           input logic pevn, input logic s2,
                           input logic [7:0] a, input logic [7:0] b);
    int          nd, n;
    logic [15:0] f1, f2, mk;
    logic        ok1, ok2;
    nd = 5 + dbl;
    n  = 2 + nd + pen + s2;
    mk = 16'((32'h1 << n) - 32'h1);
    wr(A_TM, {md, 4'h0, 1'b0, s2, mtx_pkg::FMT_ASYNC, dbl, pen, pevn});
    repeat (12 * div) @(posedge clk_sys);
    fork
      begin
        mtx_line_model_inst.rx_frame(n, div, f1, ok1);
        mtx_line_model_inst.rx_frame(n, div, f2, ok2);
      end
      begin
        wr(A_TD, {8'h0, a});
        rd_chk(A_ST, 32'h0800, 32'h0);
        wait_ready();
        wr(A_TD, {8'h0, b});
        rd_chk(A_ST, 32'h1000, 32'h0);
      end
    join
    check({ok1, f1}, {1'b1, fr(a, nd, pen, pevn) & mk});
    check({ok2, f2}, {1'b1, fr(b, nd, pen, pevn) & mk});
    repeat (4) begin
      repeat (div) @(posedge clk_sys);
      check(ser, 1'b1);
    end
    rd_chk(A_ST, 32'h1800, 32'h1800);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [15:0] f;
    logic        ok;
    logic [5:0]  d;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd_chk(A_ST, 32'hffffffff, 32'h1000);
    wr(A_ST, 16'hffff);
    rd_chk(A_ST, 32'hffffffff, 32'h1000);
    rd_chk(A_TD, 32'hffffffff, 32'h0);
    rd_chk(12'hffc, 32'hffffffff, 32'h0);
    wr(A_TM, {mtx_pkg::TXMD_B103, 12'h010});
    repeat (5) begin
      repeat (D300) @(posedge clk_sys);
      check(ser, 1'b1);
    end
    rd_chk(A_ST, 32'h1800, 32'h1000);
    wr(A_TM, {mtx_pkg::TXMD_B103, 12'h000});
    fork
      mtx_line_model_inst.rx_frame(16, D300, f, ok);
      wr(A_TD, 16'h003c);
    join
    check({ok, f}, {1'b1, 16'h3c3c});
    rd_chk(A_ST, 32'h0800, 32'h0800);
    async_run(mtx_pkg::TXMD_B103, D300, 2'h3, 1, 1, 0, 8'ha5, 8'h3c);
    async_run(mtx_pkg::TXMD_V23_1200, D1200, 2'h0, 1, 0, 1, 8'hf3, 8'h0c);
    async_run(mtx_pkg::TXMD_V23_75, 160, 2'h2, 0, 0, 0, 8'h5a, 8'h81);
    async_run(mtx_pkg::TXMD_B202_150, 80, 2'h1, 1, 1, 1, 8'h2e, 8'h11);
    // Every transmit mode with the equaliser enabled, then TXMD_V23_1200 with it disabled
    wr(A_GC, 16'h0400);
    for (int m = 0; m < 9; m++) begin
      wr(A_TM, {m[3:0], 12'h910});
      repeat (3) @(posedge clk_sys);
      check({fsk_en, tone_en, eq_en, fsk_mode, tone_sel},
            {m >= 1 && m <= 5, m >= 6, m == 2 || m == 4, m[3:0],
             4'h9});
    end
    wr(A_GC, 16'h0000);
    wr(A_TM, {mtx_pkg::TXMD_V23_1200, 12'h010});
    repeat (3) @(posedge clk_sys);
    check(eq_en, 1'b0);
    // Each detector mode against each detector input
    for (int m = 4; m < 8; m++) begin
      wr(A_RM, {m[3:0], 12'h000});
      for (int j = 0; j < 7; j++) begin
        d = (j == 6) ? 6'h3f : 6'(1 << j);
        mtx_line_model_inst.drive(d, 1'b0);
        rd_chk(A_ST, 32'h04e0, {16'h0, det_exp(m[3:0], d)});
      end
    end
    // Powersave keeps only the bus and the ring flag alive
    wr(A_RM, {mtx_pkg::RXMD_DTMF, 12'h000});
    wr(A_GC, 16'h0100);
    mtx_line_model_inst.drive(6'h3f, 1'b1);
    rd_chk(A_ST, 32'h44e0, 32'h4000);
    check({psave, rx_mode, fsk_en, tone_en, ser}, 8'h81);
    // Reset command clears the control registers
    wr(12'h004, 16'h0000);
    repeat (3) @(posedge clk_sys);
    check({psave, fsk_mode, rx_mode}, 9'h000);
    // Alternating pattern flips each bit time, then continuous mark
    wr(A_TM, {mtx_pkg::TXMD_B103, 12'h020});
    repeat (2) begin
      f[0] = ser;
      repeat (D300) @(posedge clk_sys);
      check(ser, !f[0]);
    end
    wr(A_TM, {mtx_pkg::TXMD_B103, 12'h030});
    repeat (D300 + 1) @(posedge clk_sys);
    check(ser, 1'b1);
    results();
  end
endmodule
